// >>> design/pcg_pkg.sv
// constants, offsets and reset values shared by the crc generator files
// assumes an 8-bit register port with 16-bit byte addresses
package pcg_pkg;

  localparam int ADDR_W = 16;
  localparam int BYTE_W = 8;
  localparam int CRC_W = 32;

  // register byte addresses, data bytes most significant first
  localparam logic [ADDR_W-1:0] ADDR_DATA3 = 16'h1890;
  localparam logic [ADDR_W-1:0] ADDR_DATA2 = 16'h1891;
  localparam logic [ADDR_W-1:0] ADDR_DATA1 = 16'h1892;
  localparam logic [ADDR_W-1:0] ADDR_DATA0 = 16'h1893;
  localparam logic [ADDR_W-1:0] ADDR_POLY3 = 16'h1894;
  localparam logic [ADDR_W-1:0] ADDR_POLY2 = 16'h1895;
  localparam logic [ADDR_W-1:0] ADDR_POLY1 = 16'h1896;
  localparam logic [ADDR_W-1:0] ADDR_POLY0 = 16'h1897;
  localparam logic [ADDR_W-1:0] ADDR_CTRL = 16'h1898;

  // values after reset
  localparam logic [BYTE_W-1:0] DATA_RST = 8'hff;
  localparam logic [BYTE_W-1:0] POLY3_RST = 8'h00;
  localparam logic [BYTE_W-1:0] POLY2_RST = 8'h00;
  localparam logic [BYTE_W-1:0] POLY1_RST = 8'h10;
  localparam logic [BYTE_W-1:0] POLY0_RST = 8'h21;
  localparam logic [BYTE_W-1:0] CTRL_RST = 8'h00;

  // control byte field positions
  localparam int CTRL_WIDE_BIT = 0;
  localparam int CTRL_SEED_BIT = 1;
  localparam int CTRL_CPL_BIT = 2;
  localparam int CTRL_RSVD_BIT = 3;
  localparam int CTRL_RTT_LSB = 4;
  localparam int CTRL_WTT_LSB = 6;

  // transpose field encoding, same for write and read
  localparam logic [1:0] TP_NONE = 2'h0;
  localparam logic [1:0] TP_BITS = 2'h1;
  localparam logic [1:0] TP_BOTH = 2'h2;
  localparam logic [1:0] TP_BYTES = 2'h3;

  // message byte buffer
  localparam int FIFO_DEPTH = 2;

endpackage : pcg_pkg

// >>> design/pcg_step_if.sv
// carries one byte step between the register block and the byte engine
// assumes both ends sit on the same clock; the step itself is combinational
interface pcg_step_if;
  logic [31:0] crcIn;
  logic [31:0] poly;
  logic [7:0] dataByte;
  logic wide;
  logic [31:0] crcOut;

  modport calc (input crcIn, input poly, input dataByte, input wide, output crcOut);
  modport user (output crcIn, output poly, output dataByte, output wide, input crcOut);
endinterface : pcg_step_if

// >>> design/pcg_byte_step.sv
// byte engine: folds one byte into the running checksum in one pass
// assumes the caller registers the result; no state of its own
module pcg_byte_step (
  pcg_step_if.calc stepIf
);
  import pcg_pkg::*;

  always_comb begin
    logic [31:0] acc;
    logic [31:0] polyEff;
    logic top;
    acc = stepIf.crcIn;
    polyEff = stepIf.wide ? stepIf.poly : {16'h0000, stepIf.poly[15:0]};
    top = 1'b0;
    // byte enters at the top of the active width
    if (stepIf.wide) begin
      acc = acc ^ {stepIf.dataByte, 24'h000000};
    end else begin
      acc = acc ^ {16'h0000, stepIf.dataByte, 8'h00};
    end
    for (int i = 0; i < BYTE_W; i++) begin
      top = stepIf.wide ? acc[31] : acc[15];
      acc = {acc[30:0], 1'b0};
      if (top) begin
        acc = acc ^ polyEff;
      end
    end
    // upper half is left alone in narrow mode
    stepIf.crcOut = stepIf.wide ? acc : {stepIf.crcIn[31:16], acc[15:0]};
  end

endmodule : pcg_byte_step

// >>> design/pcg_byte_fifo.sv
// small buffer with valid/ready on both sides
// assumes one clock and a synchronous active-low reset
module pcg_byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // fill side
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  // drain side
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);
  localparam logic [CW-1:0] FULL = CW'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0] wrPtr;
    logic [PW-1:0] rdPtr;
    logic [CW-1:0] count;
  } pcg_fifo_state_t;

  pcg_fifo_state_t st_r;
  pcg_fifo_state_t st_nxt;
  logic push;
  logic pop;

  assign inReady = (st_r.count != FULL);
  assign outValid = (st_r.count != '0);
  assign outData = st_r.mem[st_r.rdPtr];
  assign push = inValid && inReady;
  assign pop = outValid && outReady;

  always_comb begin
    st_nxt = st_r;
    if (push) begin
      st_nxt.mem[st_r.wrPtr] = inData;
      st_nxt.wrPtr = (st_r.wrPtr == LAST) ? '0 : st_r.wrPtr + 1'b1;
    end
    if (pop) begin
      st_nxt.rdPtr = (st_r.rdPtr == LAST) ? '0 : st_r.rdPtr + 1'b1;
    end
    if (push && !pop) begin
      st_nxt.count = st_r.count + 1'b1;
    end else if (pop && !push) begin
      st_nxt.count = st_r.count - 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

endmodule : pcg_byte_fifo

// >>> design/pcg_crc_top.sv
// programmable crc generator behind an 8-bit register port
// assumes the cpu port and the clock enable come from logic on core_clk
module pcg_crc_top
  import pcg_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // register port
  input wire logic [pcg_pkg::ADDR_W-1:0] regAddr,
  input wire logic regWrEn,
  input wire logic [pcg_pkg::BYTE_W-1:0] regWrData,
  output logic regWrReady,
  input wire logic regRdEn,
  output logic [pcg_pkg::BYTE_W-1:0] regRdData,
  output logic regRdValid,
  // power management
  input wire logic moduleClkEn,
  // observation
  output logic crcBusy,
  output logic [pcg_pkg::CRC_W-1:0] crcValue
);
  import pcg_pkg::*;

  typedef struct packed {
    logic [CRC_W-1:0] crc;
    logic [CRC_W-1:0] poly;
    logic [BYTE_W-1:0] ctrl;
    logic [BYTE_W-1:0] rdData;
    logic rdValid;
  } pcg_state_t;

  pcg_state_t st_r;
  pcg_state_t st_nxt;

  localparam pcg_state_t ST_RST = '{
    crc: {DATA_RST, DATA_RST, DATA_RST, DATA_RST},
    poly: {POLY3_RST, POLY2_RST, POLY1_RST, POLY0_RST},
    ctrl: CTRL_RST,
    rdData: '0,
    rdValid: 1'b0
  };

  // control fields
  logic wideMode;
  logic seedSel;
  logic readCpl;
  logic [1:0] write_transpose_type;
  logic [1:0] read_transpose_type;

  // decode
  logic hitData;
  logic hitPoly;
  logic hitCtrl;
  logic [1:0] byteSel;
  logic isMsgAddr;
  logic wrAccept;
  logic msgWrite;
  logic seedWrite;
  logic polyWrite;
  logic ctrlWrite;
  logic [3:0] seedLane;
  logic [3:0] polyLane;

  // what a write to the current address would do, worked out from the
  // address and the seed and width control bits so it can also steer the ready answer
  typedef enum logic [2:0] {
    WK_MESSAGE,
    WK_SEED,
    WK_POLY,
    WK_POLY_DROP,
    WK_CTRL,
    WK_IGNORE
  } pcg_wr_kind_t;

  pcg_wr_kind_t wrKind;

  // buffer and engine
  logic fifoInReady;
  logic fifoOutValid;
  logic fifoOutReady;
  logic [BYTE_W-1:0] fifoOutData;
  logic [BYTE_W-1:0] wrByteTp;
  logic stepTake;

  // read path
  logic [CRC_W-1:0] crcView;
  logic [BYTE_W-1:0] rdMux;

  pcg_step_if stepBus ();

  // reverse bit order inside one byte
  function automatic logic [BYTE_W-1:0] revByte(input logic [BYTE_W-1:0] b);
    logic [BYTE_W-1:0] r;
    r = '0;
    for (int i = 0; i < BYTE_W; i++) begin
      r[i] = b[BYTE_W-1-i];
    end
    return r;
  endfunction : revByte

  // a single byte access cannot swap bytes, so the both mode only flips bits and the bytes mode passes the byte unchanged
  function automatic logic [BYTE_W-1:0] tpByte(input logic [BYTE_W-1:0] b, input logic [1:0] tp);
    logic [BYTE_W-1:0] r;
    r = b;
    unique case (tp)
      TP_BITS, TP_BOTH: r = revByte(b);
      TP_NONE, TP_BYTES: r = b;
    endcase
    return r;
  endfunction : tpByte

  // place of each data address inside the checksum word
  function automatic logic [1:0] laneOf(input logic [ADDR_W-1:0] a);
    logic [1:0] l;
    l = 2'h0;
    unique case (a)
      ADDR_DATA3, ADDR_POLY3: l = 2'h3;
      ADDR_DATA2, ADDR_POLY2: l = 2'h2;
      ADDR_DATA1, ADDR_POLY1: l = 2'h1;
      default: l = 2'h0;
    endcase
    return l;
  endfunction : laneOf

  assign wideMode = st_r.ctrl[CTRL_WIDE_BIT];
  assign seedSel = st_r.ctrl[CTRL_SEED_BIT];
  assign readCpl = st_r.ctrl[CTRL_CPL_BIT];
  assign write_transpose_type = st_r.ctrl[CTRL_WTT_LSB +: 2];
  assign read_transpose_type = st_r.ctrl[CTRL_RTT_LSB +: 2];

  // address decode
  always_comb begin
    hitData = 1'b0;
    hitPoly = 1'b0;
    hitCtrl = 1'b0;
    unique case (regAddr)
      ADDR_DATA3, ADDR_DATA2, ADDR_DATA1, ADDR_DATA0: hitData = 1'b1;
      ADDR_POLY3, ADDR_POLY2, ADDR_POLY1, ADDR_POLY0: hitPoly = 1'b1;
      ADDR_CTRL: hitCtrl = 1'b1;
      default: begin
        hitData = 1'b0;
      end
    endcase
  end

  assign byteSel = laneOf(regAddr);

  // write classification
  always_comb begin
    wrKind = WK_IGNORE;
    unique case (regAddr)
      ADDR_DATA3, ADDR_DATA2, ADDR_DATA1: begin
        // data-mode writes here are taken and dropped
        wrKind = seedSel ? WK_SEED : WK_IGNORE;
      end
      ADDR_DATA0: begin
        wrKind = seedSel ? WK_SEED : WK_MESSAGE;
      end
      ADDR_POLY3, ADDR_POLY2: begin
        wrKind = wideMode ? WK_POLY : WK_POLY_DROP;
      end
      ADDR_POLY1, ADDR_POLY0: begin
        wrKind = WK_POLY;
      end
      ADDR_CTRL: begin
        wrKind = WK_CTRL;
      end
      default: begin
        wrKind = WK_IGNORE;
      end
    endcase
  end

  assign isMsgAddr = (wrKind == WK_MESSAGE);

  // a message write waits for a free buffer slot; anything that changes
  // the checksum set-up waits until queued bytes are folded in, so a seed
  // or width change never overtakes data written before it
  always_comb begin
    if (isMsgAddr) begin
      regWrReady = fifoInReady;
    end else begin
      regWrReady = !fifoOutValid;
    end
  end

  assign wrAccept = regWrEn && regWrReady;
  assign msgWrite = wrAccept && (wrKind == WK_MESSAGE);
  assign seedWrite = wrAccept && (wrKind == WK_SEED);
  assign polyWrite = wrAccept && (wrKind == WK_POLY);
  assign ctrlWrite = wrAccept && (wrKind == WK_CTRL);
  assign wrByteTp = tpByte(regWrData, write_transpose_type);

  // one strobe per byte lane of the checksum and polynomial registers
  for (genvar g = 0; g < CRC_W / BYTE_W; g++) begin : g_lane
    assign seedLane[g] = seedWrite && (byteSel == 2'(g));
    assign polyLane[g] = polyWrite && (byteSel == 2'(g));
  end

  pcg_byte_fifo #(
    .WIDTH(BYTE_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .inValid(msgWrite),
    .inReady(fifoInReady),
    .inData(wrByteTp),
    .outValid(fifoOutValid),
    .outReady(fifoOutReady),
    .outData(fifoOutData)
  );

  // gating the engine stalls the drain, so the buffer fills and the
  // write port backs off instead of dropping bytes
  assign fifoOutReady = moduleClkEn;
  assign stepTake = fifoOutValid && fifoOutReady;

  assign stepBus.crcIn = st_r.crc;
  assign stepBus.poly = st_r.poly;
  assign stepBus.dataByte = fifoOutData;
  assign stepBus.wide = wideMode;

  pcg_byte_step u_step (
    .stepIf(stepBus)
  );

  // value software sees; complement applies after the transpose
  always_comb begin
    crcView = st_r.crc;
    for (int k = 0; k < CRC_W / BYTE_W; k++) begin
      crcView[k*BYTE_W +: BYTE_W] = tpByte(st_r.crc[k*BYTE_W +: BYTE_W], read_transpose_type);
    end
    if (readCpl) begin
      crcView = ~crcView;
    end
  end

  // read multiplexer
  always_comb begin
    rdMux = '0;
    if (hitData) begin
      // narrow mode results sit in lanes 1 and 0; upper lanes carry
      // whatever was last put there and carry no meaning
      rdMux = crcView[byteSel*BYTE_W +: BYTE_W];
    end else if (hitPoly) begin
      rdMux = st_r.poly[byteSel*BYTE_W +: BYTE_W];
    end else if (hitCtrl) begin
      rdMux = st_r.ctrl;
      rdMux[CTRL_RSVD_BIT] = 1'b0;
    end
  end

  // next state
  always_comb begin
    st_nxt = st_r;
    st_nxt.rdValid = regRdEn;
    if (regRdEn) begin
      st_nxt.rdData = rdMux;
    end

    // engine: one byte per enabled clock
    if (stepTake) begin
      st_nxt.crc = stepBus.crcOut;
    end

    // buffer is empty whenever a seed lands, so the seed cannot race the engine
    for (int k = 0; k < CRC_W / BYTE_W; k++) begin
      if (seedLane[k]) begin
        st_nxt.crc[k*BYTE_W +: BYTE_W] = wrByteTp;
      end
      if (polyLane[k]) begin
        st_nxt.poly[k*BYTE_W +: BYTE_W] = regWrData;
      end
    end

    if (ctrlWrite) begin
      st_nxt.ctrl = regWrData;
      // reserved bit always reads back as zero
      st_nxt.ctrl[CTRL_RSVD_BIT] = 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      // all ones checksum, 0x1021 polynomial, cleared control
      st_r <= ST_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign regRdData = st_r.rdData;
  assign regRdValid = st_r.rdValid;
  assign crcBusy = fifoOutValid;
  assign crcValue = st_r.crc;

endmodule : pcg_crc_top

// >>> verification/pcg_crc_checker.sv
// assertions on the register port and observation outputs of the crc generator
// assumes it is bound into pcg_crc_top with a single clock domain
module pcg_crc_checker
  import pcg_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // register port
  input wire logic [pcg_pkg::ADDR_W-1:0] regAddr,
  input wire logic regWrEn,
  input wire logic [pcg_pkg::BYTE_W-1:0] regWrData,
  input wire logic regWrReady,
  input wire logic regRdEn,
  input wire logic [pcg_pkg::BYTE_W-1:0] regRdData,
  input wire logic regRdValid,
  // engine
  input wire logic moduleClkEn,
  input wire logic crcBusy,
  input wire logic [pcg_pkg::CRC_W-1:0] crcValue
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  AST_RST: assert property ($rose(rst_n) |-> crcValue == 32'hffffffff && !crcBusy)
    else $error("checksum not all ones after reset");
  AST_RDV: assert property (regRdEn |=> regRdValid)
    else $error("read answer missing");
  AST_NORDV: assert property (!regRdEn |=> !regRdValid)
    else $error("read answer without request");
  AST_HOLD: assert property (!regRdValid |-> $stable(regRdData))
    else $error("read data moved without a read");
  AST_HALT: assert property (!moduleClkEn && crcBusy |=> $stable(crcValue))
    else $error("checksum moved while halted");
  AST_SRC: assert property ($rose(crcBusy) |-> $past(regWrEn && regWrReady && regAddr == ADDR_DATA0))
    else $error("byte queued from a wrong address");
  AST_CHG: assert property ($changed(crcValue) |-> $past(crcBusy && moduleClkEn || regWrEn && regWrReady))
    else $error("checksum changed without cause");
  AST_TAKE: assert property (regWrEn && !crcBusy |-> regWrReady)
    else $error("write refused while idle");
  // config must never overtake queued message bytes
  AST_STALL: assert property (crcBusy && regWrEn && regAddr != ADDR_DATA0 |-> !regWrReady)
    else $error("config write taken while busy");
endmodule : pcg_crc_checker

// >>> verification/pcg_cpu_model.sv
// cpu side model: byte writes held until taken, one-cycle reads with expected values queued
// assumes calls start 2 ns after a rising edge of core_clk
module pcg_cpu_model
  import pcg_pkg::*;
(
  // clock
  input wire logic core_clk,
  // register port
  output logic [pcg_pkg::ADDR_W-1:0] regAddr,
  output logic regWrEn,
  output logic [pcg_pkg::BYTE_W-1:0] regWrData,
  input wire logic regWrReady,
  output logic regRdEn
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] q[$];
  initial begin
    regAddr = '0;
    regWrEn = 1'b0;
    regWrData = '0;
    regRdEn = 1'b0;
  end
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    int k;
    regAddr = a;
    regWrData = d;
    regWrEn = 1'b1;
    k = 0;
    do begin
      @(negedge core_clk);
      k++;
    end while (regWrReady !== 1'b1 && k < 200);
    if (regWrReady !== 1'b1) tb.hang();
    @(posedge core_clk);
    #2;
    regWrEn = 1'b0;
    // released lines show the inverse so a stale value is never mistaken
    regAddr = ~a;
    regWrData = ~d;
    @(posedge core_clk);
    #2;
  endtask : wr
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    q.push_back(e);
    regAddr = a;
    regRdEn = 1'b1;
    @(posedge core_clk);
    #2;
    regRdEn = 1'b0;
    regAddr = ~a;
    @(posedge core_clk);
    #2;
  endtask : rd
endmodule : pcg_cpu_model

// >>> verification/tb.sv
// self-checking bench: reference checksum model drives the cpu model, reads compared in order
// assumes the design files, the checker and the cpu model are compiled first
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import pcg_pkg::*;
  logic core_clk, rst_n, moduleClkEn, regWrEn, regRdEn, regWrReady, regRdValid, crcBusy;
  logic [15:0] regAddr;
  logic [7:0] regWrData, regRdData, ctl;
  logic [31:0] crcValue, m, pl;
  int err_count = 0;
  int n_tests = 0;
  pcg_crc_top dut (.core_clk, .rst_n, .regAddr, .regWrEn, .regWrData, .regWrReady, .regRdEn,
    .regRdData, .regRdValid, .moduleClkEn, .crcBusy, .crcValue);
  pcg_cpu_model cpu (.core_clk, .regAddr, .regWrEn, .regWrData, .regWrReady, .regRdEn);
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  function automatic logic [7:0] rv(input logic [7:0] b);
    for (int i = 0; i < 8; i++) rv[i] = b[7-i];
  endfunction : rv
  function automatic logic [7:0] wt(input logic [7:0] b);
    return (ctl[7:6] == TP_BITS || ctl[7:6] == TP_BOTH) ? rv(b) : b;
  endfunction : wt
  function automatic logic [31:0] st(input logic [31:0] c, input logic [7:0] d);
    if (ctl[CTRL_WIDE_BIT]) c = c ^ {d, 24'h000000};
    else c[15:0] = c[15:0] ^ {d, 8'h00};
    for (int i = 0; i < 8; i++) begin
      if (ctl[CTRL_WIDE_BIT]) c = c[31] ? (c << 1) ^ pl : c << 1;
      else c[15:0] = c[15] ? (c[15:0] << 1) ^ pl[15:0] : c[15:0] << 1;
    end
    return c;
  endfunction : st
  task automatic w(input logic [15:0] a, input logic [7:0] d);
    logic [15:0] i;
    i = a - ADDR_DATA3;
    cpu.wr(a, d);
    if (i == 8) ctl = d & 8'hf7;
    else if (i >= 4 && i < 8 && (ctl[CTRL_WIDE_BIT] || i >= 6)) pl[8*(7-i)+:8] = d;
    else if (i < 4 && ctl[CTRL_SEED_BIT]) m[8*(3-i)+:8] = wt(d);
    else if (i == 3) m = st(m, wt(d));
  endtask : w
  task automatic r(input logic [15:0] a);
    logic [15:0] i;
    logic [7:0] e;
    i = a - ADDR_DATA3;
    e = 8'h00;
    for (int k = 0; k < 50 && crcBusy !== 1'b0; k++) @(negedge core_clk);
    if (crcBusy !== 1'b0) hang();
    @(posedge core_clk);
    #2;
    if (i < 4) e = m[8*(3-i)+:8];
    if (i < 4 && (ctl[5:4] == TP_BITS || ctl[5:4] == TP_BOTH)) e = rv(e);
    if (i < 4 && ctl[CTRL_CPL_BIT]) e = ~e;
    else if (i >= 4 && i < 8) e = pl[8*(7-i)+:8];
    else if (i == 8) e = ctl;
    cpu.rd(a, e);
  endtask : r
  task automatic h(input logic [15:0] a, input logic [7:0] d);
    fork
      w(a, d);
      begin
        repeat (3) @(negedge core_clk);
        chk_rdy(regWrReady, 1'b0);
        @(posedge core_clk);
        #2;
        moduleClkEn = 1'b1;
      end
    join
  endtask : h
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    n_tests++;
    if (g !== e) begin
      err_count++;
      $display("FAIL %0t got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic chk_rdy(input logic g, input logic e);
    n_tests++;
    if (g !== e) begin
      err_count++;
      $display("FAIL %0t write ready %b expected %b", $time, g, e);
    end
  endtask : chk_rdy
  task automatic test_done();
    // a read that never answered counts against the run
    if (cpu.q.size() != 0) err_count++;
    if (err_count == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : test_done
  task automatic hang();
    err_count++;
    test_done();
  endtask : hang
  // sampled mid-cycle, where the registered answer has settled
  always @(negedge core_clk) begin
    if (regRdValid === 1'b1 && cpu.q.size() == 0) begin
      err_count++;
      $display("FAIL %0t read answer with no request", $time);
    end else if (regRdValid === 1'b1) begin
      chk(regRdData, cpu.q.pop_front());
    end
  end
  initial begin
    rst_n = 1'b0;
    moduleClkEn = 1'b1;
    ctl = CTRL_RST;
    m = 32'hffffffff;
    pl = 32'h00001021;
    void'($urandom(53));
    repeat (12) @(posedge core_clk);
    #2;
    rst_n = 1'b1;
    for (int a = 0; a < 10; a++) r(ADDR_DATA3 + 16'(a));
    w(ADDR_CTRL, 8'h03);
    for (int a = 0; a < 4; a++) begin
      w(ADDR_DATA3 + 16'(a), 8'($urandom));
      w(ADDR_POLY3 + 16'(a), 8'(32'h04c11db7 >> 8 * (3 - a)));
    end
    for (int t = 0; t < 8; t++) begin
      w(ADDR_CTRL, {t[1:0], t[1:0], 1'b1, t[2], 2'b01});
      w(ADDR_DATA0, 8'($urandom));
      w(ADDR_DATA3 + 16'(t % 3), 8'($urandom));
      for (int a = 0; a < 5; a++) r(ADDR_DATA3 + 16'(a == 4 ? 8 : a));
    end
    moduleClkEn = 1'b0;
    w(ADDR_DATA0, 8'($urandom));
    w(ADDR_DATA0, 8'($urandom));
    h(ADDR_DATA0, 8'($urandom));
    moduleClkEn = 1'b0;
    w(ADDR_DATA0, 8'($urandom));
    h(ADDR_CTRL, 8'h02);
    w(ADDR_DATA1, 8'($urandom));
    w(ADDR_DATA0, 8'($urandom));
    w(ADDR_POLY3, 8'hee);
    w(ADDR_CTRL, 8'h00);
    repeat (4) w(ADDR_DATA0, 8'($urandom));
    for (int a = 2; a < 7; a++) r(ADDR_DATA3 + 16'(a));
    cpu.wr(16'h18a0, 8'h77);
    r(16'h18a0);
    r(ADDR_CTRL);
    test_done();
  end
endmodule : tb
bind pcg_crc_top pcg_crc_checker chk (.core_clk, .rst_n, .regAddr, .regWrEn, .regWrData, .regWrReady,
  .regRdEn, .regRdData, .regRdValid, .moduleClkEn, .crcBusy, .crcValue);
